// ---- banked_data_memory_decoder.sv ----
// banked data memory decoder with scratch and common ram storage
`include "dmem_defs.svh"
`default_nettype none

// Summary of operation
// - Offsets 00h to 0Bh of every bank go to the core registers, forwarded with the full address including the bank.
// - Offsets 0Ch to 1Fh of every bank go to the peripheral register space.
// - Each bank can hold up to 80 scratch ram bytes after the peripheral register space.
// - Sixteen bytes of common ram are reachable from whichever bank is selected.
// - Offsets 70h to 7Fh of every bank hit the same common ram bytes as bank 0.
// - Reads of unpopulated locations, empty peripheral slots included, return zero.
// - Scratch ram is also reachable through the indirect pointers as one contiguous region.
// - The small variant populates 80 bytes in bank 0 and 32 bytes at 0A0h-0BFh in bank 1 only.
// - The large variant populates 20h-6Fh in banks 0, 1 and 2 and nothing in higher banks.
// - Data memory is 32 banks of 128 bytes on a 12-bit address.
// - Direct accesses use the last bank number written to the bank selector plus the offset.
module banked_data_memory_decoder
  import dmem_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire accReq_t    req,
  input  wire logic [7:0] coreRdData,
  input  wire logic [7:0] periphRdData,
  input  wire logic       periphHit,
  output fwdReq_t         coreReq_reg,
  output fwdReq_t         periphReq_reg,
  output logic [4:0]      bankSel_reg,
  output logic [7:0]      rdData_reg,
  output logic            rdValid_reg
);

  localparam logic [7:0] SCRATCH_TOTAL = LARGE_VARIANT ? `DM_LARGE_TOTAL : `DM_SMALL_TOTAL;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [11:0] decAddr;
  logic [4:0]  decBank;
  logic [6:0]  decOfs;
  region_t     decRegion;
  logic [7:0]  scratchIdx;
  logic [3:0]  commonIdx;
  logic        scratchPop;
  logic        isBankSel;
  logic [7:0]  scratchRd;
  logic [7:0]  commonRd;

  // full address: bank selector plus offset for direct accesses
  always_comb begin
    case (req.mode)
      MODE_DIRECT: decAddr = {bankSel_reg, req.addr[6:0]};
      default:     decAddr = req.addr;
    endcase
  end

  assign decBank = decAddr[11:7];
  assign decOfs  = decAddr[6:0];

  // which banks populate the scratch window
  always_comb begin
    if (LARGE_VARIANT) begin
      scratchPop = decBank < `DM_LARGE_BANKS;
    end else begin
      scratchPop = (decBank == 5'h00) ||
                   ((decBank == 5'h01) && (decOfs <= `DM_SMALL_B1_LAST));
    end
  end

  // region select and physical indices
  always_comb begin
    decRegion  = REG_NONE;
    scratchIdx = 8'h00;
    commonIdx  = decOfs[3:0];
    if (req.mode == MODE_LINEAR) begin
      if ((req.addr[11:8] == 4'h0) && (req.addr[7:0] < SCRATCH_TOTAL)) begin
        decRegion  = REG_SCRATCH;
        scratchIdx = req.addr[7:0];
      end
    end else if (decOfs <= `DM_CORE_LAST) begin
      decRegion = REG_CORE;
    end else if (decOfs <= `DM_PERIPH_LAST) begin
      decRegion = REG_PERIPH;
    end else if (decOfs >= `DM_COMMON_FIRST) begin
      decRegion = REG_COMMON;
    end else if (scratchPop) begin
      decRegion  = REG_SCRATCH;
      scratchIdx = 8'(({3'h0, decBank} * `DM_SCRATCH_PER_BANK) + ({1'b0, decOfs} - {1'b0, `DM_SCRATCH_FIRST}));
    end
  end

  assign isBankSel = (decRegion == REG_CORE) && (decOfs == `DM_BANKSEL_OFS);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic scratchWe;
  logic commonWe;

  // only populated locations are ever written
  assign scratchWe = req.valid && req.write && (decRegion == REG_SCRATCH);
  assign commonWe  = req.valid && req.write && (decRegion == REG_COMMON);

  byte_store #(
    .DEPTH (`DM_SCRATCH_DEPTH),
    .IW    (8)
  ) scratchStore (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wrEn    (scratchWe),
    .wrIdx   (scratchIdx),
    .wrData  (req.wrData),
    .rdIdx   (scratchIdx),
    .rdData  (scratchRd)
  );

  byte_store #(
    .DEPTH (`DM_COMMON_DEPTH),
    .IW    (4)
  ) commonStore (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wrEn    (commonWe),
    .wrIdx   (commonIdx),
    .wrData  (req.wrData),
    .rdIdx   (commonIdx),
    .rdData  (commonRd)
  );

  // ----------------------------------------------------------------
  // bank selector
  // ----------------------------------------------------------------
  // takes effect for the next direct access
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bankSel_reg <= `DM_BANKSEL_RESET;
    end else if (req.valid && req.write && isBankSel) begin
      bankSel_reg <= req.wrData[4:0];
    end
  end

  // ----------------------------------------------------------------
  // first stage: forwarded accesses and local ram read
  // ----------------------------------------------------------------
  logic       stgValid_reg;
  logic       stgWrite_reg;
  region_t    stgRegion_reg;
  logic       stgBankSel_reg;
  logic [7:0] ramData_reg;

  // core and peripheral accesses go out one cycle after the request
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      coreReq_reg   <= '0;
      periphReq_reg <= '0;
    end else begin
      coreReq_reg   <= '{valid: req.valid && (decRegion == REG_CORE), write: req.write,
                         addr: decAddr, wrData: req.wrData};
      periphReq_reg <= '{valid: req.valid && (decRegion == REG_PERIPH), write: req.write,
                         addr: decAddr, wrData: req.wrData};
    end
  end

  // remember what the request was for the answer stage
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stgValid_reg   <= 1'b0;
      stgWrite_reg   <= 1'b0;
      stgRegion_reg  <= REG_NONE;
      stgBankSel_reg <= 1'b0;
      ramData_reg    <= 8'h00;
    end else begin
      stgValid_reg   <= req.valid;
      stgWrite_reg   <= req.write;
      stgRegion_reg  <= decRegion;
      stgBankSel_reg <= isBankSel;
      // bank selector value is caught at the taking edge, so a selector write just behind a
      // selector read cannot leak its new value into the older read answer
      if (isBankSel) begin
        ramData_reg <= {3'h0, bankSel_reg};
      end else begin
        ramData_reg <= (decRegion == REG_COMMON) ? commonRd : scratchRd;
      end
    end
  end

  // ----------------------------------------------------------------
  // second stage: read answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= stgValid_reg && !stgWrite_reg;
      case (stgRegion_reg)
        REG_CORE:    rdData_reg <= stgBankSel_reg ? ramData_reg : coreRdData;
        REG_PERIPH:  rdData_reg <= periphHit ? periphRdData : 8'h00;
        REG_SCRATCH: rdData_reg <= ramData_reg;
        REG_COMMON:  rdData_reg <= ramData_reg;
        default:     rdData_reg <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  core_route_a: assert property (
    req.valid && (req.mode != MODE_LINEAR) && (decOfs <= 7'h0B) |=> coreReq_reg.valid && !periphReq_reg.valid)
    else $error("core offset not routed to core registers");

  periph_route_a: assert property (
    req.valid && (req.mode != MODE_LINEAR) && (decOfs >= 7'h0C) && (decOfs <= 7'h1F)
    |=> periphReq_reg.valid && (periphReq_reg.addr == $past(decAddr)))
    else $error("peripheral offset not routed to peripheral space");

  scratch_bound_a: assert property (
    decRegion == REG_SCRATCH |-> scratchIdx < SCRATCH_TOTAL)
    else $error("scratch index beyond populated ram");

  common_mirror_a: assert property (
    (decRegion == REG_COMMON) |-> (decOfs >= 7'h70) && (commonIdx == decOfs[3:0]))
    else $error("common ram not mirrored by low offset bits");

  common_write_a: assert property (
    req.valid && req.write && (req.mode != MODE_LINEAR) && (decOfs >= 7'h70) |-> commonWe && !scratchWe)
    else $error("common ram write lost");

  unpop_zero_a: assert property (
    stgValid_reg && !stgWrite_reg && (stgRegion_reg == REG_NONE) |=> rdValid_reg && (rdData_reg == 8'h00))
    else $error("unpopulated read not zero");

  linear_map_a: assert property (
    req.valid && (req.mode == MODE_LINEAR) && (req.addr < 12'(SCRATCH_TOTAL))
    |=> (stgRegion_reg == REG_SCRATCH) && ($past(scratchIdx) == $past(req.addr[7:0])))
    else $error("linear index not mapped onto scratch ram");

  small_bank1_a: assert property (
    !LARGE_VARIANT && (req.mode != MODE_LINEAR) && (decBank == 5'h01) && (decOfs >= 7'h40) && (decOfs <= 7'h6F)
    |-> decRegion == REG_NONE)
    else $error("small variant populates bank 1 above 0BFh");

  large_banks_a: assert property (
    LARGE_VARIANT && (req.mode != MODE_LINEAR) && (decBank >= 5'h03) && (decOfs >= 7'h20) && (decOfs <= 7'h6F)
    |-> decRegion == REG_NONE)
    else $error("large variant populates a high bank");

  read_latency_a: assert property (
    req.valid && !req.write |-> ##2 rdValid_reg)
    else $error("read answer not two cycles after request");

  bank_select_a: assert property (
    req.valid && req.write && isBankSel |=> (bankSel_reg == $past(req.wrData[4:0])) ##0
    (!req.valid || req.mode != MODE_DIRECT || decBank == bankSel_reg))
    else $error("bank selector write not applied to direct access");

  drop_write_a: assert property (
    decRegion == REG_NONE |-> !scratchWe && !commonWe)
    else $error("write to unpopulated location reached storage");

  common_other_bank_c: cover property (req.valid && (decRegion == REG_COMMON) && (decBank != 5'h00));
  linear_read_c: cover property (req.valid && !req.write && (req.mode == MODE_LINEAR));
  bank_write_c: cover property (req.valid && req.write && isBankSel);
  unpop_read_c: cover property (req.valid && !req.write && (decRegion == REG_NONE));

endmodule
`default_nettype wire

// ---- banked_data_memory_decoder_tb_top.sv ----
// self-checking bench for the banked data memory decoder, both variants side by side
`default_nettype none
module banked_data_memory_decoder_tb_top;
  import dmem_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        w;
    accMode_t    m;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  eS;
    logic [7:0]  eL;
  } row_t;

  localparam accMode_t dirM = MODE_DIRECT;
  localparam accMode_t indM = MODE_INDIRECT;
  localparam accMode_t linM = MODE_LINEAR;

  logic       sys_clk;
  logic       sys_rst;
  accReq_t    req;
  logic [7:0] coreRdData;
  logic [7:0] periphRdData;
  logic       periphHit;
  fwdReq_t    cReqS, pReqS, cReqL, pReqL;
  logic [4:0] bankS, bankL;
  logic [7:0] rdDataS, rdDataL;
  logic       rdValidS, rdValidL;
  logic [11:0] lastPa, lastCa;
  logic [11:0] lastPaL, lastCaL;
  logic [11:0] lastPw;
  int         fails = 0;
  int         checks = 0;

  // ------------------------------------------------------------
  // ordinary accesses: inputs beside the answers of small and large
  // ------------------------------------------------------------
  row_t rows [0:28] = '{
    '{1'b1, indM, 12'h020, 8'h11, 8'h00, 8'h00}, '{1'b1, indM, 12'h0A0, 8'h22, 8'h00, 8'h00},
    '{1'b1, indM, 12'h0BF, 8'h88, 8'h00, 8'h00}, '{1'b1, indM, 12'h0C0, 8'h33, 8'h00, 8'h00},
    '{1'b1, indM, 12'h120, 8'h44, 8'h00, 8'h00}, '{1'b1, indM, 12'h1A0, 8'h55, 8'h00, 8'h00},
    '{1'b1, indM, 12'h070, 8'h66, 8'h00, 8'h00}, '{1'b1, linM, 12'h051, 8'h77, 8'h00, 8'h00},
    '{1'b0, indM, 12'h020, 8'h00, 8'h11, 8'h11}, '{1'b0, indM, 12'h0BF, 8'h00, 8'h88, 8'h88},
    '{1'b0, indM, 12'h0C0, 8'h00, 8'h00, 8'h33}, '{1'b0, indM, 12'h120, 8'h00, 8'h00, 8'h44},
    '{1'b0, indM, 12'h1A0, 8'h00, 8'h00, 8'h00}, '{1'b0, indM, 12'hFF0, 8'h00, 8'h66, 8'h66},
    '{1'b0, indM, 12'h0A1, 8'h00, 8'h77, 8'h77}, '{1'b0, linM, 12'h000, 8'h00, 8'h11, 8'h11},
    '{1'b0, linM, 12'h050, 8'h00, 8'h22, 8'h22}, '{1'b0, linM, 12'h070, 8'h00, 8'h00, 8'h33},
    '{1'b0, linM, 12'h0A0, 8'h00, 8'h00, 8'h44}, '{1'b0, linM, 12'h100, 8'h00, 8'h00, 8'h00},
    '{1'b0, indM, 12'h003, 8'h00, 8'hFC, 8'hFC}, '{1'b0, indM, 12'h183, 8'h00, 8'h7C, 8'h7C},
    '{1'b0, indM, 12'h00C, 8'h00, 8'hA9, 8'hA9}, '{1'b0, indM, 12'h00F, 8'h00, 8'h00, 8'h00},
    '{1'b1, dirM, 12'h008, 8'h02, 8'h00, 8'h00}, '{1'b0, dirM, 12'h070, 8'h00, 8'h66, 8'h66},
    '{1'b0, dirM, 12'h020, 8'h00, 8'h00, 8'h44}, '{1'b0, dirM, 12'h008, 8'h00, 8'h02, 8'h02},
    '{1'b0, indM, 12'h108, 8'h00, 8'h02, 8'h02}
  };

  // ------------------------------------------------------------
  // design instances and far-side model
  // ------------------------------------------------------------
  banked_data_memory_decoder #(.LARGE_VARIANT(1'b0)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
    .coreRdData(coreRdData), .periphRdData(periphRdData), .periphHit(periphHit), .coreReq_reg(cReqS),
    .periphReq_reg(pReqS), .bankSel_reg(bankS), .rdData_reg(rdDataS), .rdValid_reg(rdValidS));
  banked_data_memory_decoder #(.LARGE_VARIANT(1'b1)) dutLarge (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
    .coreRdData(coreRdData), .periphRdData(periphRdData), .periphHit(periphHit), .coreReq_reg(cReqL),
    .periphReq_reg(pReqL), .bankSel_reg(bankL), .rdData_reg(rdDataL), .rdValid_reg(rdValidL));
  core_side_model farSide (.sys_clk(sys_clk), .coreReq(cReqS), .periphReq(pReqS),
    .coreRdData(coreRdData), .periphRdData(periphRdData), .periphHit(periphHit));

  // clock of 100 ns period
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // raise one access just after a falling edge
  task automatic drive(input logic w, input accMode_t m, input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{1'b1, w, m, a, d};
  endtask

  // drop the strobe, record forwarded addresses, wait a bounded time for the answer
  task automatic ans(input logic w, input logic [7:0] eS, input logic [7:0] eL);
    int n;
    n = 0;
    lastPa = '0;
    lastCa = '0;
    lastPaL = '0;
    lastCaL = '0;
    lastPw = '0;
    @(negedge sys_clk);
    req.valid = 1'b0;
    while (n < 4 && rdValidS !== 1'b1) begin
      if (pReqS.valid === 1'b1) begin
        lastPa = pReqS.addr;
        lastPw = {3'h0, pReqS.write, pReqS.wrData};
      end
      if (cReqS.valid === 1'b1) lastCa = cReqS.addr;
      if (pReqL.valid === 1'b1) lastPaL = pReqL.addr;
      if (cReqL.valid === 1'b1) lastCaL = cReqL.addr;
      @(negedge sys_clk);
      n++;
    end
    if (!w) begin
      chk("rdValid small", {11'h0, rdValidS}, 12'h001);
      chk("rdValid large", {11'h0, rdValidL}, 12'h001);
      chk("rdData small", {4'h0, rdDataS}, {4'h0, eS});
      chk("rdData large", {4'h0, rdDataL}, {4'h0, eL});
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #(3000 * 100);
    fails++;
    results();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    req = '0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("bankSel in reset", {7'h0, bankS}, 12'h000);
    chk("bankSel large in reset", {7'h0, bankL}, 12'h000);
    chk("rdValid in reset", {11'h0, rdValidS}, 12'h000);
    chk("rdValid large in reset", {11'h0, rdValidL}, 12'h000);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      drive(rows[i].w, rows[i].m, rows[i].a, rows[i].d);
      ans(rows[i].w, rows[i].eS, rows[i].eL);
    end
    // bank selector write followed at once by a direct read in the new bank
    drive(1'b1, dirM, 12'h008, 8'h00);
    drive(1'b0, dirM, 12'h020, 8'h00);
    ans(1'b0, 8'h11, 8'h11);
    // common write in bank 0 read back at once from bank 6
    drive(1'b1, dirM, 12'h07F, 8'h5A);
    drive(1'b0, indM, 12'h37F, 8'h00);
    ans(1'b0, 8'h5A, 8'h5A);
    // peripheral write forwarded with its full address
    drive(1'b1, indM, 12'h28C, 8'h77);
    ans(1'b1, 8'h00, 8'h00);
    chk("periph addr", lastPa, 12'h28C);
    chk("periph addr large", lastPaL, 12'h28C);
    chk("periph write data", lastPw, 12'h177);
    // core read in a high bank forwarded with its full address
    drive(1'b0, indM, 12'h185, 8'h00);
    ans(1'b0, 8'h7A, 8'h7A);
    chk("core addr", lastCa, 12'h185);
    chk("core addr large", lastCaL, 12'h185);
    // second reset clears storage and the bank selector
    drive(1'b1, dirM, 12'h008, 8'h03);
    ans(1'b1, 8'h00, 8'h00);
    @(negedge sys_clk);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    chk("bankSel after reset", {7'h0, bankS}, 12'h000);
    chk("bankSel large after reset", {7'h0, bankL}, 12'h000);
    sys_rst = 1'b0;
    drive(1'b0, indM, 12'h020, 8'h00);
    ans(1'b0, 8'h00, 8'h00);
    results();
  end
endmodule
`default_nettype wire

// ---- byte_store.sv ----
// flip-flop byte storage with one write port and one read port
`default_nettype none
module byte_store #(
  parameter int DEPTH = 16,
  parameter int IW    = 4
) (
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          wrEn,
  input  wire logic [IW-1:0] wrIdx,
  input  wire logic [7:0]    wrData,
  input  wire logic [IW-1:0] rdIdx,
  output logic      [7:0]    rdData
);

  logic [7:0] mem_reg [DEPTH];

  // storage cleared at reset, written by index
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (wrEn && (int'(wrIdx) < DEPTH)) begin
      mem_reg[wrIdx] <= wrData;
    end
  end

  // read port, out of range reads zero
  assign rdData = (int'(rdIdx) < DEPTH) ? mem_reg[rdIdx] : 8'h00;

endmodule
`default_nettype wire

// ---- core_side_model.sv ----
// far-side responder standing in for the core registers and the peripheral slots
`default_nettype none
module core_side_model
  import dmem_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire fwdReq_t coreReq,
  input  wire fwdReq_t periphReq,
  output logic [7:0]   coreRdData,
  output logic [7:0]   periphRdData,
  output logic         periphHit
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] noise = 8'h3C;

  // pattern that moves every cycle, so a stale answer can never match
  always @(posedge sys_clk) begin
    noise <= {noise[6:0], ~noise[7]};
  end

  // answers depend on the address so that each slot is told apart
  assign coreRdData   = coreReq.valid ? ~coreReq.addr[7:0] : noise;
  assign periphRdData = periphReq.valid ? (periphReq.addr[7:0] ^ 8'hA5) : ~noise;
  // slots ending in 3h, 7h, Bh or Fh stand empty
  assign periphHit    = periphReq.valid ? (periphReq.addr[1:0] != 2'b11) : noise[0];
endmodule
`default_nettype wire

// ---- dmem_defs.svh ----
// address map constants of the banked data memory decoder
`ifndef DMEM_DEFS_SVH
`define DMEM_DEFS_SVH

// ----------------------------------------------------------------
// in-bank offsets
// ----------------------------------------------------------------
`define DM_CORE_LAST      7'h0B
`define DM_BANKSEL_OFS    7'h08
`define DM_PERIPH_LAST    7'h1F
`define DM_SCRATCH_FIRST  7'h20
`define DM_SCRATCH_LAST   7'h6F
`define DM_COMMON_FIRST   7'h70
`define DM_SMALL_B1_LAST  7'h3F

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define DM_SCRATCH_PER_BANK 8'h50
`define DM_LARGE_BANKS      5'h03
`define DM_SMALL_TOTAL      8'h70
`define DM_LARGE_TOTAL      8'hF0
`define DM_SCRATCH_DEPTH    240
`define DM_COMMON_DEPTH     16
`define DM_BANKSEL_RESET    5'h00

`endif

// ---- dmem_pkg.sv ----
// types shared by the banked data memory decoder
`default_nettype none
package dmem_pkg;

  // how the core forms the address of an access
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_LINEAR
  } accMode_t;

  // region that an address decodes to
  typedef enum logic [2:0] {
    REG_CORE,
    REG_PERIPH,
    REG_SCRATCH,
    REG_COMMON,
    REG_NONE
  } region_t;

  // access from the processor core
  typedef struct packed {
    logic        valid;
    logic        write;
    accMode_t    mode;
    logic [11:0] addr;
    logic [7:0]  wrData;
  } accReq_t;

  // access forwarded to the core register or peripheral register space
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [7:0]  wrData;
  } fwdReq_t;

endpackage
`default_nettype wire
